//--- hdl/adcr_control.sv
// adcr_control: register file and conversion sequencer for the 12-bit adc
//
// Design decisions made here: the APB interface to the registers and the register addresses.
module adcr_control
  import adcr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] core_result,
  output adcr_analog_type analog_ctl,
  output logic conversion_done
);

  logic [7:0] conversion_control;
  logic [7:0] input_and_clock_select;
  logic [7:0] reference_and_gain_control;
  logic [7:0] bandgap_control;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;
  logic conversion_busy;
  logic start_armed;
  logic start_pulse;
  logic [6:0] div_count;
  logic clk_tick;
  logic [4:0] tick_count;
  logic finish;

  logic wr_en;
  logic rd_addr_ok;
  logic [7:0] wbyte;

  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;

  always_comb begin
    unique case (paddr)
      ADDR_CONV_CONTROL, ADDR_INPUT_CLOCK, ADDR_REF_GAIN, ADDR_BANDGAP,
      ADDR_RESULT_LOW, ADDR_RESULT_HIGH: rd_addr_ok = 1'b1;
      default: rd_addr_ok = 1'b0;
    endcase
  end

  // unmapped addresses answer with an error; writes to results are refused
  assign pslverr = psel && penable && (!rd_addr_ok ||
    (pwrite && (paddr == ADDR_RESULT_LOW || paddr == ADDR_RESULT_HIGH)));

  logic [7:0] conv_view;
  always_comb begin
    conv_view = conversion_control;
    conv_view[BUSY_BIT] = conversion_busy;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        ADDR_CONV_CONTROL: prdata <= {24'h00_0000, conv_view};
        ADDR_INPUT_CLOCK: prdata <= {24'h00_0000, input_and_clock_select};
        ADDR_REF_GAIN: prdata <= {24'h00_0000, reference_and_gain_control};
        ADDR_BANDGAP: prdata <= {24'h00_0000, bandgap_control};
        ADDR_RESULT_LOW: prdata <= {24'h00_0000, result_low_byte};
        ADDR_RESULT_HIGH: prdata <= {24'h00_0000, result_high_byte};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // masks keep unimplemented bits at zero and busy out of software reach
  always_ff @(posedge mclk) begin
    if (rst) begin
      conversion_control <= REG_RESET;
      input_and_clock_select <= REG_RESET;
      reference_and_gain_control <= REG_RESET;
      bandgap_control <= REG_RESET;
    end else if (wr_en) begin
      unique case (paddr)
        ADDR_CONV_CONTROL:
          conversion_control <= wbyte & CONV_CONTROL_WMASK;
        ADDR_INPUT_CLOCK:
          input_and_clock_select <= wbyte & INPUT_CLOCK_MASK;
        ADDR_REF_GAIN:
          reference_and_gain_control <= wbyte & REF_GAIN_MASK;
        ADDR_BANDGAP:
          bandgap_control <= wbyte & BANDGAP_MASK;
        default: ;
      endcase
    end
  end

  // a high written to start arms; the following low write fires if it leaves enable set
  always_ff @(posedge mclk) begin
    if (rst) begin
      start_armed <= 1'b0;
    end else begin
      start_armed <= conversion_control[START_BIT];
    end
  end
  assign start_pulse = start_armed && !conversion_control[START_BIT]
    && conversion_control[ENABLE_BIT];

  // divider runs while the converter is enabled and is held at zero otherwise; tick marks one converter clock period
  always_ff @(posedge mclk) begin
    if (rst || !conversion_control[ENABLE_BIT]) begin
      div_count <= 7'h00;
    end else begin
      div_count <= div_count + 7'h01;
    end
  end

  logic [6:0] div_mask;
  assign div_mask = 7'((8'h01 << input_and_clock_select[2:0]) - 8'h01);
  assign clk_tick = conversion_control[ENABLE_BIT] &&
    ((div_count & div_mask) == div_mask);

  assign finish = conversion_busy && clk_tick && tick_count == CONV_TICKS_LAST;

  always_ff @(posedge mclk) begin
    if (rst) begin
      conversion_busy <= 1'b0;
      tick_count <= 5'h00;
    end else if (start_pulse) begin
      conversion_busy <= 1'b1;
      tick_count <= 5'h00;
    end else if (!conversion_control[ENABLE_BIT] || finish) begin
      conversion_busy <= 1'b0;
    end else if (conversion_busy && clk_tick) begin
      tick_count <= tick_count + 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      result_high_byte <= 8'h00;
      result_low_byte <= 8'h00;
    end else if (finish && conversion_control[ENABLE_BIT]) begin
      if (conversion_control[FORMAT_BIT]) begin
        result_high_byte <= {4'h0, core_result[11:8]};
        result_low_byte <= core_result[7:0];
      end else begin
        result_high_byte <= core_result[11:4];
        result_low_byte <= {core_result[3:0], 4'h0};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      conversion_done <= 1'b0;
    end else begin
      conversion_done <= finish;
    end
  end

  // analog routing decode
  logic [3:0] src;
  logic ext_path;
  assign src = input_and_clock_select[7:4];
  assign ext_path = (src == 4'h0) || (src == 4'h4) || (src[3:2] == 2'b11);

  genvar ch;
  generate
    for (ch = 0; ch < 16; ch++) begin : g_chan
      assign analog_ctl.external_channel_onehot[ch] = ext_path &&
        conversion_control[3:0] == 4'(ch);
    end
  endgenerate

  always_comb begin
    unique case (src)
      4'h1: analog_ctl.internal_source = AIN_SUPPLY;
      4'h2: analog_ctl.internal_source = AIN_SUPPLY_HALF;
      4'h3: analog_ctl.internal_source = AIN_SUPPLY_QUARTER;
      4'h5: analog_ctl.internal_source = AIN_AMP;
      4'h6: analog_ctl.internal_source = AIN_AMP_HALF;
      4'h7: analog_ctl.internal_source = AIN_AMP_QUARTER;
      4'h8, 4'h9, 4'hA, 4'hB: analog_ctl.internal_source = AIN_GROUND;
      default: analog_ctl.internal_source = AIN_EXTERNAL;
    endcase
  end

  always_comb begin
    unique case (reference_and_gain_control[3:2])
      2'b00: analog_ctl.reference = REF_SUPPLY;
      2'b01: analog_ctl.reference = REF_EXTERNAL;
      default: analog_ctl.reference = REF_AMP;
    endcase
  end

  assign analog_ctl.ext_reference_connect =
    reference_and_gain_control[3:2] == 2'b01;
  assign analog_ctl.converter_on = conversion_control[ENABLE_BIT];
  assign analog_ctl.gain_amp_on = reference_and_gain_control[7];
  assign analog_ctl.gain_amp_from_bandgap =
    reference_and_gain_control[4];
  assign analog_ctl.gain_select = reference_and_gain_control[1:0];
  assign analog_ctl.bandgap_on = bandgap_control[0];
  assign analog_ctl.conv_clock_tick = clk_tick;

  // helper: cycles since start for the duration check
  logic [12:0] busy_age;
  always_ff @(posedge mclk) begin
    if (rst || !conversion_busy) begin
      busy_age <= 13'h0000;
    end else begin
      busy_age <= busy_age + 13'h0001;
    end
  end

  busy_sets_a: assert property (@(posedge mclk) disable iff (rst)
    start_pulse |=> conversion_busy)
    else $error("busy not set after start");

  start_seq_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(conversion_busy) |-> $past(start_armed) &&
      !$past(conversion_control[START_BIT]))
    else $error("busy rose without start sequence");

  busy_ends_a: assert property (@(posedge mclk) disable iff (rst)
    finish |=> !conversion_busy ##0 conversion_done)
    else $error("busy did not clear at end");

  busy_bound_a: assert property (@(posedge mclk) disable iff (rst)
    busy_age <= 13'h0800)
    else $error("conversion ran too long");

  result_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !conversion_control[ENABLE_BIT] |=> $stable(result_high_byte) &&
      $stable(result_low_byte))
    else $error("result changed while disabled");

  left_fmt_a: assert property (@(posedge mclk) disable iff (rst)
    finish && !conversion_control[FORMAT_BIT] |=>
      result_low_byte[3:0] == 4'h0 &&
      result_high_byte == $past(core_result[11:4]))
    else $error("left format wrong");

  right_fmt_a: assert property (@(posedge mclk) disable iff (rst)
    finish && conversion_control[FORMAT_BIT] |=>
      result_high_byte[7:4] == 4'h0 &&
      result_low_byte == $past(core_result[7:0]))
    else $error("right format wrong");

  ext_off_a: assert property (@(posedge mclk) disable iff (rst)
    analog_ctl.internal_source != AIN_EXTERNAL |->
      analog_ctl.external_channel_onehot == 16'h0000)
    else $error("external path joined to internal source");

  unimpl_a: assert property (@(posedge mclk) disable iff (rst)
    input_and_clock_select[3] == 1'b0 && bandgap_control[7:1] == 7'h00 &&
      reference_and_gain_control[6:5] == 2'b00)
    else $error("unimplemented bit set");

endmodule

//--- hdl/adcr_pkg.sv
// package: register map, field layout and analog select codes for adc control
package adcr_pkg;

  localparam logic [11:0] ADDR_CONV_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_INPUT_CLOCK = 12'h004;
  localparam logic [11:0] ADDR_REF_GAIN = 12'h008;
  localparam logic [11:0] ADDR_BANDGAP = 12'h00C;
  localparam logic [11:0] ADDR_RESULT_LOW = 12'h010;
  localparam logic [11:0] ADDR_RESULT_HIGH = 12'h014;

  localparam int START_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int ENABLE_BIT = 5;
  localparam int FORMAT_BIT = 4;

  localparam logic [7:0] CONV_CONTROL_WMASK = 8'hBF;
  localparam logic [7:0] INPUT_CLOCK_MASK = 8'hF7;
  localparam logic [7:0] REF_GAIN_MASK = 8'h9F;
  localparam logic [7:0] BANDGAP_MASK = 8'h01;
  localparam logic [7:0] REG_RESET = 8'h00;

  // conversion length in converter clock periods
  localparam int CONV_TICKS = 16;
  localparam logic [4:0] CONV_TICKS_LAST = 5'(CONV_TICKS - 1);

  typedef enum logic [3:0] {
    AIN_EXTERNAL,
    AIN_SUPPLY,
    AIN_SUPPLY_HALF,
    AIN_SUPPLY_QUARTER,
    AIN_AMP,
    AIN_AMP_HALF,
    AIN_AMP_QUARTER,
    AIN_GROUND
  } adcr_ain_type;

  typedef enum logic [1:0] {
    REF_SUPPLY,
    REF_EXTERNAL,
    REF_AMP
  } adcr_ref_type;

  typedef struct packed {
    logic converter_on;
    logic [15:0] external_channel_onehot;
    adcr_ain_type internal_source;
    adcr_ref_type reference;
    logic ext_reference_connect;
    logic gain_amp_on;
    logic gain_amp_from_bandgap;
    logic [1:0] gain_select;
    logic bandgap_on;
    logic conv_clock_tick;
  } adcr_analog_type;

endpackage

//--- bench/adcr_core_model.sv
// analog core model: hands back a sample while the converter is powered
module adcr_core_model
  import adcr_pkg::*;
(
  input wire logic mclk,
  input wire logic [11:0] sample,
  input wire adcr_analog_type analog_ctl,
  output logic [11:0] core_result
);
  timeunit 1ns;
  timeprecision 1ns;
  initial core_result = 12'h000;
  // a powered-down core holds no valid data, so keep the value moving
  always @(posedge mclk) begin
    core_result <= analog_ctl.converter_on ? sample : ~core_result;
  end
endmodule

//--- bench/testbench.sv
// testbench: register access, analog routing and conversion checks
module testbench
  import adcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0, sample = '0, core_result, res;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, conversion_done, err, fmt;
  logic [7:0] c, s, g, b, ctrl;
  logic [15:0] ex = '0;
  adcr_analog_type ctl;
  int failures = 0, check_count = 0, cycles = 0, n;

  always #20 mclk = ~mclk;

  adcr_control dut(.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_result(core_result), .analog_ctl(ctl),
    .conversion_done(conversion_done));
  adcr_core_model core(.mclk(mclk), .sample(sample), .analog_ctl(ctl),
    .core_result(core_result));

  task print_verdict;
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task apb(input logic w, input logic [11:0] a, input logic [7:0] v);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(v);
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  function automatic adcr_ain_type exp_src(input logic [3:0] v);
    if (v[3]) return v[2] ? AIN_EXTERNAL : AIN_GROUND;
    if (v[1:0] == 2'b00) return AIN_EXTERNAL;
    return adcr_ain_type'(4'(v[1:0]) + (v[2] ? 4'h3 : 4'h0));
  endfunction

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      print_verdict;
    end
  end

  initial begin
    void'($urandom(92));
    repeat (4) @(posedge mclk);
    rst <= 0;
    for (int a = 0; a < 16; a += 4) begin
      apb(0, 12'(a), 0);
      chk(rd, 0);
    end
    apb(1, ADDR_CONV_CONTROL, 8'h40);
    apb(0, ADDR_CONV_CONTROL, 0);
    chk(rd, 0);
    apb(0, 12'h018, 0);
    chk(err, 1);
    apb(1, ADDR_RESULT_LOW, 8'h5A);
    chk(err, 1);
    for (int i = 0; i < 24; i++) begin
      c = 8'($urandom) & 8'h1F;
      s = 8'($urandom);
      g = 8'($urandom);
      // bandgap kept on so it is running before it feeds the amplifier
      b = 8'($urandom) | 8'h01;
      apb(1, ADDR_CONV_CONTROL, c);
      apb(1, ADDR_INPUT_CLOCK, s);
      apb(1, ADDR_BANDGAP, b);
      apb(1, ADDR_REF_GAIN, g);
      apb(0, ADDR_INPUT_CLOCK, 0);
      chk(rd, s & INPUT_CLOCK_MASK);
      apb(0, ADDR_REF_GAIN, 0);
      chk(rd, g & REF_GAIN_MASK);
      apb(0, ADDR_BANDGAP, 0);
      chk(rd, b & BANDGAP_MASK);
      chk(ctl.external_channel_onehot, exp_src(s[7:4]) == AIN_EXTERNAL ?
        32'h0000_0001 << c[3:0] : 0);
      chk(ctl.internal_source, exp_src(s[7:4]));
      chk(ctl.reference, g[3] ? REF_AMP : adcr_ref_type'(g[2]));
      chk({ctl.ext_reference_connect, ctl.gain_amp_on,
        ctl.gain_amp_from_bandgap, ctl.gain_select, ctl.bandgap_on},
        {g[3:2] == 2'b01, g[7], g[4], g[1:0], b[0]});
    end
    for (int k = 0; k < 8; k++) begin
      apb(1, ADDR_INPUT_CLOCK, 8'(k));
      apb(1, ADDR_CONV_CONTROL, 8'h20);
      // tick is sampled mid-cycle, where it has settled
      do @(negedge mclk); while (ctl.conv_clock_tick !== 1'b1);
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (ctl.conv_clock_tick !== 1'b1);
      chk(n, 1 << k);
    end
    // pass 4 starts with the converter off, pass 5 aborts mid-conversion
    for (int i = 0; i < 6; i++) begin
      fmt = i[0];
      res = 12'($urandom);
      sample <= res;
      // divide by 32 gives about 781 kHz from the 25 MHz clock
      apb(1, ADDR_INPUT_CLOCK, 8'h05);
      ctrl = {2'b00, i != 4, fmt, 4'h0};
      apb(1, ADDR_CONV_CONTROL, ctrl | 8'h80);
      apb(1, ADDR_CONV_CONTROL, ctrl);
      chk(ctl.converter_on, i != 4);
      if (i == 5) apb(1, ADDR_CONV_CONTROL, 8'h00);
      if (i < 4) begin
        apb(0, ADDR_CONV_CONTROL, 0);
        chk(rd[BUSY_BIT], 1);
        do @(negedge mclk); while (conversion_done !== 1'b1);
        ex = fmt ? {4'h0, res} : {res, 4'h0};
      end else begin
        repeat (100) @(posedge mclk);
      end
      apb(0, ADDR_CONV_CONTROL, 0);
      chk(rd[BUSY_BIT], 0);
      apb(0, ADDR_RESULT_HIGH, 0);
      chk(rd, ex[15:8]);
      apb(0, ADDR_RESULT_LOW, 0);
      chk(rd, ex[7:0]);
    end
    print_verdict;
  end
endmodule
